//--- sbcpl_pkg.sv
package sbcpl_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [6:0] ADDR_DUTY = 7'h18;
	localparam logic [6:0] ADDR_RATE = 7'h1c;
	localparam logic [6:0] ADDR_HWCFG = 7'h1d;
	localparam logic [6:0] ADDR_SCR_LO = 7'h1e;
	localparam logic [6:0] ADDR_SCR_HI = 7'h1f;

	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [1:0] RST_RATE = 2'h0;
	localparam logic RST_TRIP = 1'b0;
	localparam logic [1:0] RST_TRIM = 2'h1;
	localparam logic [7:0] RST_SCR = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	localparam int RATE_LSB = 0;
	localparam int TRIP_BIT = 2;
	localparam int TRIM_LSB = 0;

	// gpio configuration codes that hand the pin to the pwm
	localparam logic [2:0] GPIO_PWM_LS = 3'h6;
	localparam logic [2:0] GPIO_PWM_HS = 3'h7;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int FREQ_HZ_0 = 100;
	localparam int FREQ_HZ_1 = 200;
	localparam int FREQ_HZ_2 = 325;
	localparam int FREQ_HZ_3 = 400;
	localparam int DUTY_STEPS = 255;
	localparam logic [7:0] STEP_LAST = 8'hfe;

	// one duty step, in clock cycles, rounded down
	localparam int STEP_CYC_0 = CLK_HZ / (FREQ_HZ_0 * DUTY_STEPS);
	localparam int STEP_CYC_1 = CLK_HZ / (FREQ_HZ_1 * DUTY_STEPS);
	localparam int STEP_CYC_2 = CLK_HZ / (FREQ_HZ_2 * DUTY_STEPS);
	localparam int STEP_CYC_3 = CLK_HZ / (FREQ_HZ_3 * DUTY_STEPS);

	typedef logic [11:0] sbcpl_sub_t;

endpackage

//--- sbcpl_pwm_if.sv
interface sbcpl_pwm_if;
	logic [7:0] duty;
	logic [1:0] rate;
	logic level;

	modport regs (output duty, output rate, input level);
	modport gen (input duty, input rate, output level);
endinterface

//--- sbcpl_pwm_gen.sv
module sbcpl_pwm_gen (
	input wire logic clock,
	input wire logic rst_n,
	sbcpl_pwm_if.gen pwm
);

	typedef struct packed {
		logic [1:0] rate;
		logic [7:0] duty;
		sbcpl_pkg::sbcpl_sub_t sub;
		logic [7:0] step;
		logic level;
	} sbcpl_gen_s;

	sbcpl_gen_s st_r;
	sbcpl_gen_s st_nxt;

	function automatic sbcpl_pkg::sbcpl_sub_t step_last(input logic [1:0] rate);
		case (rate)
			2'h0: step_last = sbcpl_pkg::sbcpl_sub_t'(sbcpl_pkg::STEP_CYC_0 - 1);
			2'h1: step_last = sbcpl_pkg::sbcpl_sub_t'(sbcpl_pkg::STEP_CYC_1 - 1);
			2'h2: step_last = sbcpl_pkg::sbcpl_sub_t'(sbcpl_pkg::STEP_CYC_2 - 1);
			default: step_last = sbcpl_pkg::sbcpl_sub_t'(sbcpl_pkg::STEP_CYC_3 - 1);
		endcase
	endfunction

	// ************************************************************
	// period counter
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		if (st_r.sub == step_last(st_r.rate)) begin
			st_nxt.sub = '0;
			if (st_r.step == sbcpl_pkg::STEP_LAST) begin
				// new settings only at the boundary, no runt periods
				st_nxt.step = 8'h00;
				st_nxt.rate = pwm.rate;
				st_nxt.duty = pwm.duty;
			end else begin
				st_nxt.step = st_r.step + 8'h01;
			end
		end else begin
			st_nxt.sub = st_r.sub + 12'h001;
		end
		// 255 steps per period: 0 never on, ff always on
		st_nxt.level = (st_nxt.step < st_nxt.duty);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= '{rate: sbcpl_pkg::RST_RATE, duty: sbcpl_pkg::RST_DUTY,
				sub: '0, step: 8'h00, level: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pwm.level = st_r.level;

endmodule // sbcpl_pwm_gen

//--- sbcpl_regs.sv
// Strobed register access was chosen for this implementation.
module sbcpl_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic soft_rst,
	input wire logic normal_mode,
	input wire logic freeze_bit,
	input wire logic chip_sel_n,
	input wire logic [2:0] gpio_cfg,
	output logic gpio_hs_on,
	output logic gpio_ls_on,
	output logic thermal_trip_sel,
	output logic [1:0] supply_current_limit_trim,
	output logic cfg_locked
);

	typedef struct packed {
		logic [7:0] pulse_duty_setting;
		logic [1:0] pulse_rate_sel;
		logic thermal_trip_sel;
		logic [1:0] supply_current_limit_trim;
		logic [7:0] scratch_low_byte;
		logic [7:0] scratch_high_byte;
		logic locked;
		logic csn_q;
		logic [7:0] rdata;
		logic hs_on;
		logic ls_on;
	} sbcpl_regs_s;

	sbcpl_regs_s st_r;
	sbcpl_regs_s st_nxt;

	sbcpl_pwm_if pwm ();

	sbcpl_pwm_gen u_gen (
		.clock(clock),
		.rst_n(rst_n),
		.pwm(pwm)
	);

	assign pwm.duty = st_r.pulse_duty_setting;
	assign pwm.rate = st_r.pulse_rate_sel;

	// ************************************************************
	// register logic
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.csn_q = chip_sel_n;
		// lock arms on the rising edge of chip select only
		if (freeze_bit && !st_r.csn_q && chip_sel_n) begin
			st_nxt.locked = 1'b1;
		end

		if (reg_wr) begin
			case (reg_addr)
				sbcpl_pkg::ADDR_DUTY: st_nxt.pulse_duty_setting = reg_wdata;
				sbcpl_pkg::ADDR_RATE: begin
					st_nxt.pulse_rate_sel = reg_wdata[sbcpl_pkg::RATE_LSB +: 2];
				end
				sbcpl_pkg::ADDR_HWCFG: begin
					if (!st_r.locked) begin
						st_nxt.thermal_trip_sel = reg_wdata[sbcpl_pkg::TRIP_BIT];
						st_nxt.supply_current_limit_trim =
							reg_wdata[sbcpl_pkg::TRIM_LSB +: 2];
					end
				end
				sbcpl_pkg::ADDR_SCR_LO: begin
					if (normal_mode) begin
						st_nxt.scratch_low_byte = reg_wdata;
					end
				end
				sbcpl_pkg::ADDR_SCR_HI: begin
					if (normal_mode) begin
						st_nxt.scratch_high_byte = reg_wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// soft reset beats a write in the same cycle; scratch untouched
		if (soft_rst) begin
			st_nxt.pulse_duty_setting = sbcpl_pkg::RST_DUTY;
			st_nxt.pulse_rate_sel = sbcpl_pkg::RST_RATE;
			if (!st_r.locked) begin
				st_nxt.thermal_trip_sel = sbcpl_pkg::RST_TRIP;
				st_nxt.supply_current_limit_trim = sbcpl_pkg::RST_TRIM;
			end
		end

		st_nxt.rdata = sbcpl_pkg::READ_NONE;
		if (reg_rd) begin
			case (reg_addr)
				sbcpl_pkg::ADDR_DUTY: st_nxt.rdata = st_r.pulse_duty_setting;
				sbcpl_pkg::ADDR_RATE: st_nxt.rdata = {6'h00, st_r.pulse_rate_sel};
				sbcpl_pkg::ADDR_HWCFG: begin
					st_nxt.rdata = {5'h00, st_r.thermal_trip_sel,
						st_r.supply_current_limit_trim};
				end
				sbcpl_pkg::ADDR_SCR_LO: st_nxt.rdata = st_r.scratch_low_byte;
				sbcpl_pkg::ADDR_SCR_HI: st_nxt.rdata = st_r.scratch_high_byte;
				default: st_nxt.rdata = sbcpl_pkg::READ_NONE;
			endcase
		end

		// pin follows the pwm only in the two pwm modes
		st_nxt.hs_on = (gpio_cfg == sbcpl_pkg::GPIO_PWM_HS) && pwm.level;
		st_nxt.ls_on = (gpio_cfg == sbcpl_pkg::GPIO_PWM_LS) && pwm.level;
	end

	// rst_n is the power-on reset: the only thing that clears scratch and lock
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= '{pulse_duty_setting: sbcpl_pkg::RST_DUTY,
				pulse_rate_sel: sbcpl_pkg::RST_RATE,
				thermal_trip_sel: sbcpl_pkg::RST_TRIP,
				supply_current_limit_trim: sbcpl_pkg::RST_TRIM,
				scratch_low_byte: sbcpl_pkg::RST_SCR,
				scratch_high_byte: sbcpl_pkg::RST_SCR,
				locked: 1'b0, csn_q: 1'b1, rdata: sbcpl_pkg::READ_NONE,
				hs_on: 1'b0, ls_on: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign gpio_hs_on = st_r.hs_on;
	assign gpio_ls_on = st_r.ls_on;
	assign thermal_trip_sel = st_r.thermal_trip_sel;
	assign supply_current_limit_trim = st_r.supply_current_limit_trim;
	assign cfg_locked = st_r.locked;

endmodule // sbcpl_regs

//--- sbcpl_regs_assertions.sv
module sbcpl_regs_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic soft_rst,
	input wire logic normal_mode,
	input wire logic freeze_bit,
	input wire logic chip_sel_n,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] gpio_cfg,
	input wire logic gpio_hs_on,
	input wire logic gpio_ls_on,
	input wire logic thermal_trip_sel,
	input wire logic cfg_locked,
	input wire logic [1:0] supply_current_limit_trim
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ****************
	// register checks
	// ****************
	a_rate_pad_zero: assert property ($past(reg_rd) && $past(reg_addr) == 7'h1c |->
		reg_rdata[7:2] == 6'h00) else $error("rate pad bits set");
	a_hw_pad_zero: assert property ($past(reg_rd) && $past(reg_addr) == 7'h1d |->
		reg_rdata[7:3] == 5'h00) else $error("hw pad bits set");
	a_trim_wr: assert property (reg_wr && reg_addr == 7'h1d && !cfg_locked && !soft_rst |=>
		{thermal_trip_sel, supply_current_limit_trim} == $past(reg_wdata[2:0]))
		else $error("trip or trim not written");
	a_soft_dflt: assert property (soft_rst && !cfg_locked |=>
		!thermal_trip_sel && supply_current_limit_trim == 2'h1) else $error("soft reset default");
	a_lock_hold: assert property (cfg_locked |=> $stable(thermal_trip_sel) &&
		$stable(supply_current_limit_trim)) else $error("locked field moved");
	a_lock_sticky: assert property (cfg_locked |=> cfg_locked) else $error("lock lost");
	// lock may land one or two edges after the select rise
	a_lock_edge: assert property (freeze_bit && chip_sel_n && !$past(chip_sel_n) |->
		##[1:2] cfg_locked) else $error("lock not taken");
	a_lock_cause: assert property (!freeze_bit && !$past(freeze_bit) && !$past(freeze_bit, 2) &&
		!$past(cfg_locked, 2) |-> !cfg_locked) else $error("lock without freeze");
	a_gpio_off: assert property ((gpio_cfg[2:1] != 2'h3) [*3] |->
		!gpio_hs_on && !gpio_ls_on) else $error("pin driven outside pwm mode");
	c_lock_soft: cover property (cfg_locked && soft_rst);
	c_soft: cover property (soft_rst && !cfg_locked);
	c_hw_wr: cover property (reg_wr && reg_addr == 7'h1d);
endmodule // sbcpl_regs_chk

bind sbcpl_regs sbcpl_regs_chk i_chk (
	.clock(clock),
	.rst_n(rst_n),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.soft_rst(soft_rst),
	.normal_mode(normal_mode),
	.freeze_bit(freeze_bit),
	.chip_sel_n(chip_sel_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.gpio_cfg(gpio_cfg),
	.gpio_hs_on(gpio_hs_on),
	.gpio_ls_on(gpio_ls_on),
	.thermal_trip_sel(thermal_trip_sel),
	.cfg_locked(cfg_locked),
	.supply_current_limit_trim(supply_current_limit_trim)
);

//--- sbcpl_mcu_model.sv
module sbcpl_mcu_model (
	input wire logic clock,
	output logic [6:0] reg_addr = 7'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// bus cycles
	// ****************
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		// data stands one cycle only, so take it just past the edge
		#1 d = reg_rdata;
	endtask
endmodule // sbcpl_mcu_model

//--- sbcpl_regs_tb_top.sv
module sbcpl_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, soft_rst = 1'b0, normal_mode = 1'b1;
	logic freeze_bit = 1'b0, chip_sel_n = 1'b1, gpio_hs_on, gpio_ls_on, thermal_trip_sel, cfg_locked;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [2:0] gpio_cfg = 3'h0;
	logic [1:0] supply_current_limit_trim;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	sbcpl_regs i_dut (
		.clock(clock),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.soft_rst(soft_rst),
		.normal_mode(normal_mode),
		.freeze_bit(freeze_bit),
		.chip_sel_n(chip_sel_n),
		.gpio_cfg(gpio_cfg),
		.gpio_hs_on(gpio_hs_on),
		.gpio_ls_on(gpio_ls_on),
		.thermal_trip_sel(thermal_trip_sel),
		.supply_current_limit_trim(supply_current_limit_trim),
		.cfg_locked(cfg_locked)
	);
	sbcpl_mcu_model i_mcu (
		.clock(clock),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);
	// ****************
	// checking
	// ****************
	initial forever #12.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		i_mcu.rd(a, d);
		chk(d, e);
	endtask
	task automatic pulse_soft;
		@(posedge clock) soft_rst <= 1'b1;
		@(posedge clock) soft_rst <= 1'b0;
		@(posedge clock) #1;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_regs;
		rchk(7'h1d, 8'h01);
		rchk(7'h1f, 8'h00);
		rchk(7'h10, 8'h00);
		for (int i = 0; i < 8; i++) begin
			i_mcu.wr(7'h1c, 8'hfc | i[7:0]);
			rchk(7'h1c, {6'h00, i[1:0]});
			i_mcu.wr(7'h1d, 8'hf8 | i[7:0]);
			#1 chk({5'h00, thermal_trip_sel, supply_current_limit_trim}, i[7:0]);
			rchk(7'h1d, i[7:0]);
		end
		$display("t_regs done");
	endtask
	task automatic t_scratch;
		i_mcu.wr(7'h1e, 8'h5a);
		i_mcu.wr(7'h1f, 8'ha5);
		@(posedge clock) normal_mode <= 1'b0;
		i_mcu.wr(7'h1e, 8'h3c);
		i_mcu.wr(7'h1f, 8'hc3);
		pulse_soft;
		chk({5'h00, thermal_trip_sel, supply_current_limit_trim}, 8'h01);
		rchk(7'h1e, 8'h5a);
		rchk(7'h1f, 8'ha5);
		@(posedge clock) normal_mode <= 1'b1;
		$display("t_scratch done");
	endtask
	task automatic t_pwm0;
		i_mcu.wr(7'h18, 8'h00);
		for (int c = 6; c < 8; c++) begin
			@(posedge clock) gpio_cfg <= c[2:0];
			repeat (40) @(posedge clock) #1 chk({6'h00, gpio_hs_on, gpio_ls_on}, 8'h00);
		end
		$display("t_pwm0 done");
	endtask
	task automatic t_lock;
		i_mcu.wr(7'h1d, 8'h06);
		@(posedge clock) freeze_bit <= 1'b1;
		chip_sel_n <= 1'b0;
		@(posedge clock) chip_sel_n <= 1'b1;
		#1 chk({7'h00, cfg_locked}, 8'h00);
		repeat (3) @(posedge clock);
		#1 chk({7'h00, cfg_locked}, 8'h01);
		pulse_soft;
		i_mcu.wr(7'h1d, 8'h01);
		rchk(7'h1d, 8'h06);
		$display("t_lock done");
	endtask
	// power-up in mid-run: only this clears scratch and lock
	task automatic t_por;
		@(posedge clock) rst_n <= 1'b0;
		freeze_bit <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rchk(7'h1e, 8'h00);
		rchk(7'h1f, 8'h00);
		rchk(7'h1d, 8'h01);
		chk({7'h00, cfg_locked}, 8'h00);
		i_mcu.wr(7'h1d, 8'h04);
		rchk(7'h1d, 8'h04);
		$display("t_por done");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		t_scratch;
		t_pwm0;
		t_lock;
		t_por;
		print_verdict;
	end
endmodule // sbcpl_regs_tb_top
